// *** pkg/ndc_pkg.sv ***
`default_nettype none
package ndc_pkg;
    // Datapath widths
    localparam int ACC_W = 72;
    localparam int WORD_W = 36;
    localparam int BUS_W = 32;
    localparam int ADDR_W = 8;
    localparam int IRQ_N = 2;
    // Shift counter values
    localparam logic [5:0] SK_FULL = 6'h24;
    localparam logic [5:0] SK_ZERO = 6'h00;
    localparam logic [5:0] SK_ONE = 6'h01;
    localparam logic [5:0] SK_AFTER_FIRST = 6'h23;
    localparam logic [5:0] SK_AFTER_SECOND = 6'h22;
    // Bit positions
    localparam int SIGN_BIT = 35;
    localparam int OVF_BIT = 36;
    localparam int DIVIDEND_BIT = 71;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_ACC0 = 8'h08;
    localparam logic [7:0] OFS_ACC1 = 8'h0C;
    localparam logic [7:0] OFS_ACC2 = 8'h10;
    localparam logic [7:0] OFS_DIV0 = 8'h14;
    localparam logic [7:0] OFS_DIV1 = 8'h18;
    localparam logic [7:0] OFS_QUO0 = 8'h1C;
    localparam logic [7:0] OFS_QUO1 = 8'h20;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
    // Field positions
    localparam int CTRL_START_BIT = 0;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_CHECK_BIT = 1;
    // Reset values
    localparam logic [BUS_W-1:0] RDATA_RST = 32'h0000_0000;
    localparam logic [ACC_W-1:0] ACC_RST = 72'h00_0000_0000_0000_0000;
    localparam logic [WORD_W-1:0] WORD_RST = 36'h0_0000_0000;
    localparam logic [IRQ_N-1:0] IRQ_RST = 2'h0;
    // Top level sequence states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SHIFT,
        ST_DIV,
        ST_END
    } ndc_state_type;
endpackage
`default_nettype wire

// *** pkg/ndc_core_if.sv ***
`default_nettype none
interface ndc_core_if;
    import ndc_pkg::*;
    logic [ACC_W-1:0] add_a;     // Adder operand, accumulator
    logic [ACC_W-1:0] add_b;     // Adder operand, extended divisor
    logic [ACC_W-1:0] add_sum;   // One's complement sum
    logic [IRQ_N-1:0] irq_ev;    // Event pulses
    logic irq_wr_stat;           // Status write strobe
    logic irq_wr_mask;           // Mask write strobe
    logic [IRQ_N-1:0] irq_wdata; // Write data for status or mask
    logic [IRQ_N-1:0] irq_stat;  // Sticky status
    logic [IRQ_N-1:0] irq_mask;  // Mask
    logic irq_out;               // Registered interrupt level
    modport add_mp(input add_a, input add_b, output add_sum);
    modport irq_mp(input irq_ev, input irq_wr_stat, input irq_wr_mask,
                   input irq_wdata, output irq_stat, output irq_mask,
                   output irq_out);
endinterface
`default_nettype wire

// *** rtl/ndc_oc_adder.sv ***
`default_nettype none
module ndc_oc_adder
    import ndc_pkg::*;
(
    ndc_core_if.add_mp add // Operands and sum
);
    ////////////////////////////////////////////////////////////////////////
    logic [ACC_W:0] raw; // Plain sum with carry out

    // End-around carry keeps one's complement arithmetic
    always_comb begin
        raw = {1'b0, add.add_a} + {1'b0, add.add_b};
        add.add_sum = raw[ACC_W-1:0] + {{(ACC_W-1){1'b0}}, raw[ACC_W]};
    end
endmodule
`default_nettype wire

// *** rtl/ndc_irq_ctl.sv ***
`default_nettype none
module ndc_irq_ctl
    import ndc_pkg::*;
(
    input wire logic clk_sys_i, // System clock
    input wire logic rst_i,     // Async reset, high
    ndc_core_if.irq_mp irq      // Event and register strobes
);
    ////////////////////////////////////////////////////////////////////////
    logic [IRQ_N-1:0] stat_q, stat_d; // Sticky status
    logic [IRQ_N-1:0] mask_q, mask_d; // Enable mask
    logic irq_q, irq_d;               // Interrupt level

    // Set wins over a write-one clear in the same cycle
    always_comb begin
        stat_d = stat_q;
        mask_d = mask_q;
        if (irq.irq_wr_stat) begin
            stat_d = stat_q & ~irq.irq_wdata;
        end
        stat_d = stat_d | irq.irq_ev;
        if (irq.irq_wr_mask) begin
            mask_d = irq.irq_wdata;
        end
        irq_d = |(stat_d & mask_d);
    end

    // Register status, mask and level
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            stat_q <= IRQ_RST;
            mask_q <= IRQ_RST;
            irq_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
        end
    end

    assign irq.irq_stat = stat_q;
    assign irq.irq_mask = mask_q;
    assign irq.irq_out = irq_q;
endmodule
`default_nettype wire

// *** rtl/ndc_divide_core.sv ***
// Register access over Avalon-MM and the register offsets were left to the implementer.
`default_nettype none
module ndc_divide_core
    import ndc_pkg::*;
(
    input wire logic clk_sys_i,                // System clock
    input wire logic rst_i,                    // Async reset, high
    input wire logic [ADDR_W-1:0] avs_address_i, // Byte address
    input wire logic avs_read_i,               // Read request
    input wire logic avs_write_i,              // Write request
    input wire logic [BUS_W-1:0] avs_writedata_i, // Write data
    output logic [BUS_W-1:0] avs_readdata_o,   // Read data
    output logic avs_waitrequest_o,            // Stall, high
    output logic irq_o,                        // Interrupt level
    output logic busy_o,                       // Sequence running
    output logic div_check_stop_o,             // Overflow stop pulse
    output logic div_done_o                    // Completion pulse
);
    ////////////////////////////////////////////////////////////////////////
    // Declarations
    ndc_core_if core (); // Adder and interrupt carrier

    ndc_state_type state_q, state_d;        // Sequence state
    logic [ACC_W-1:0] acc_q, acc_d;         // Accumulator
    logic [WORD_W-1:0] x_q, x_d;            // Divisor register
    logic [WORD_W-1:0] q_q, q_d;            // Quotient register
    logic [5:0] sk_q, sk_d;                 // Shift counter
    logic div_seq_q, div_seq_d;             // Divide sequence flag
    logic div_step_q, div_step_d;           // Divide step flag
    logic restore_x_q, restore_x_d;         // Restore divisor flag
    logic delayed_add_q, delayed_add_d;     // Delayed add flag
    logic b_probe_q, b_probe_d;             // Probe flag, third cycle of a step
    logic c_probe_q, c_probe_d;             // Final probe flag
    logic e_probe_q, e_probe_d;             // End probe flag
    logic ext_seq_q, ext_seq_d;             // Extend sequence flag
    logic div_case_q, div_case_d;           // Dividend was negative
    logic check_q, check_d;                 // Divide check stop pulse
    logic done_q, done_d;                   // Done pulse
    logic busy_q, busy_d;                   // Busy level
    logic wait_q, wait_d;                   // Waitrequest
    logic [BUS_W-1:0] rdata_q, rdata_d;     // Read data
    logic wr_fire;                          // Write takes effect
    logic finish;                           // Step closes this cycle
    logic same_sign;                        // Partial dividend vs divisor
    logic check_fail;                       // Overflow detected
    logic [WORD_W-1:0] mag;                 // Divisor magnitude

    ////////////////////////////////////////////////////////////////////////
    // Submodules
    ndc_oc_adder u_adder (
        .add (core.add_mp)
    );

    ndc_irq_ctl u_irq (
        .clk_sys_i (clk_sys_i),
        .rst_i (rst_i),
        .irq (core.irq_mp)
    );

    ////////////////////////////////////////////////////////////////////////
    // Helper terms
    always_comb begin
        wr_fire = avs_write_i & ~wait_q;
        same_sign = (acc_q[SIGN_BIT] == x_q[SIGN_BIT]);
        finish = (state_q == ST_DIV) & ~div_step_q & ~delayed_add_q &
                 ((b_probe_q & (sk_q == SK_ZERO)) | c_probe_q);
        check_fail = 1'b0;
        if (sk_q == SK_AFTER_FIRST) begin
            check_fail = (acc_q[SIGN_BIT] != acc_q[OVF_BIT]);
        end else if (sk_q == SK_AFTER_SECOND) begin
            check_fail = (q_q[0] == q_q[1]);
        end
        mag = x_q[SIGN_BIT] ? ~x_q : x_q;
    end

    // Adder operands: divisor, or its magnitude in ST_END, sign-extended into the upper half
    always_comb begin
        core.add_a = acc_q;
        if (state_q == ST_END) begin
            core.add_b = {{(ACC_W-WORD_W){mag[SIGN_BIT]}}, mag};
        end else begin
            core.add_b = {{(ACC_W-WORD_W){x_q[SIGN_BIT]}}, x_q};
        end
    end

    // Interrupt strobes
    always_comb begin
        core.irq_ev = '0;
        core.irq_ev[IRQ_DONE_BIT] = done_q;
        core.irq_ev[IRQ_CHECK_BIT] = check_q;
        core.irq_wr_stat = wr_fire & (avs_address_i == OFS_IRQ_STAT);
        core.irq_wr_mask = wr_fire & (avs_address_i == OFS_IRQ_MASK);
        core.irq_wdata = avs_writedata_i[IRQ_N-1:0];
    end
    ////////////////////////////////////////////////////////////////////////
    // Sequencer and register writes
    always_comb begin
        state_d = state_q;
        acc_d = acc_q;
        x_d = x_q;
        q_d = q_q;
        sk_d = sk_q;
        div_seq_d = div_seq_q;
        div_step_d = div_step_q;
        restore_x_d = restore_x_q;
        delayed_add_d = delayed_add_q;
        b_probe_d = b_probe_q;
        c_probe_d = c_probe_q;
        e_probe_d = e_probe_q;
        ext_seq_d = ext_seq_q;
        div_case_d = div_case_q;
        check_d = 1'b0;
        done_d = 1'b0;
        case (state_q)
            ST_IDLE: begin
                // Operand loads only while idle
                if (wr_fire) begin
                    if (avs_address_i == OFS_ACC0) begin
                        acc_d[31:0] = avs_writedata_i;
                    end else if (avs_address_i == OFS_ACC1) begin
                        acc_d[63:32] = avs_writedata_i;
                    end else if (avs_address_i == OFS_ACC2) begin
                        acc_d[71:64] = avs_writedata_i[7:0];
                    end else if (avs_address_i == OFS_DIV0) begin
                        x_d[31:0] = avs_writedata_i;
                    end else if (avs_address_i == OFS_DIV1) begin
                        x_d[35:32] = avs_writedata_i[3:0];
                    end else if (avs_address_i == OFS_QUO0) begin
                        q_d[31:0] = avs_writedata_i;
                    end else if (avs_address_i == OFS_QUO1) begin
                        q_d[35:32] = avs_writedata_i[3:0];
                    end else if (avs_address_i == OFS_CTRL &&
                                 avs_writedata_i[CTRL_START_BIT]) begin
                        div_case_d = acc_q[DIVIDEND_BIT];
                        sk_d = SK_FULL;
                        ext_seq_d = 1'b1;
                        state_d = ST_SHIFT;
                    end
                end
            end
            ST_SHIFT: begin
                // Initial positioning shift, one place per clock
                acc_d = {acc_q[ACC_W-2:0], acc_q[ACC_W-1]};
                sk_d = sk_q - SK_ONE;
                if (sk_q == SK_ONE) begin
                    div_seq_d = 1'b1;
                    div_step_d = 1'b1;
                    sk_d = SK_FULL;
                    state_d = ST_DIV;
                end
            end
            ST_DIV: begin
                if (div_step_q) begin
                    // First step: rotate left, decide add or subtract
                    acc_d = {acc_q[ACC_W-2:0], acc_q[ACC_W-1]};
                    sk_d = sk_q - SK_ONE;
                    delayed_add_d = 1'b1;
                    div_step_d = 1'b0;
                    if (same_sign) begin
                        x_d = ~x_q;
                        q_d[0] = 1'b1;
                        restore_x_d = 1'b1;
                    end
                    // Opposite signs leave divisor and bit 0 alone
                end else if (delayed_add_q) begin
                    // Sum lands with bit 35 as the new sign
                    acc_d = core.add_sum;
                    delayed_add_d = 1'b0;
                    b_probe_d = 1'b1;
                end else if (b_probe_q) begin
                    b_probe_d = 1'b0;
                    c_probe_d = (sk_q != SK_ZERO);
                end else if (c_probe_q) begin
                    c_probe_d = 1'b0;
                end
                if (finish) begin
                    // Close the step: restore, rotate quotient, rearm
                    if (restore_x_q) begin
                        x_d = ~x_q;
                        restore_x_d = 1'b0;
                    end
                    q_d = {q_q[WORD_W-2:0], q_q[WORD_W-1]};
                    if (check_fail) begin
                        // Overflow: abort back to idle
                        check_d = 1'b1;
                        div_seq_d = 1'b0;
                        ext_seq_d = 1'b0;
                        state_d = ST_IDLE;
                    end else if (sk_q != SK_ZERO) begin
                        div_step_d = 1'b1;
                    end else begin
                        e_probe_d = 1'b1;
                        ext_seq_d = 1'b0;
                        state_d = ST_END;
                    end
                end
            end
            ST_END: begin
                // End correction, then resume the sequencer
                if (acc_q[OVF_BIT]) begin
                    acc_d = core.add_sum;
                end
                if (acc_q[OVF_BIT] != div_case_q) begin
                    q_d[0] = q_q[WORD_W-1];
                end
                e_probe_d = 1'b0;
                div_seq_d = 1'b0;
                done_d = 1'b1;
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        busy_d = (state_d != ST_IDLE);
    end
    ////////////////////////////////////////////////////////////////////////
    // Avalon slave: one wait cycle, then the answer
    always_comb begin
        wait_d = ~((avs_read_i | avs_write_i) & wait_q);
        rdata_d = rdata_q;
        if (avs_read_i & wait_q) begin
            if (avs_address_i == OFS_CTRL) begin
                rdata_d = {31'h0000_0000, busy_q};
            end else if (avs_address_i == OFS_STATUS) begin
                rdata_d = {20'h0_0000, sk_q, div_case_q, ext_seq_q,
                           e_probe_q, restore_x_q, div_seq_q, busy_q};
            end else if (avs_address_i == OFS_ACC0) begin
                rdata_d = acc_q[31:0];
            end else if (avs_address_i == OFS_ACC1) begin
                rdata_d = acc_q[63:32];
            end else if (avs_address_i == OFS_ACC2) begin
                rdata_d = {24'h00_0000, acc_q[71:64]};
            end else if (avs_address_i == OFS_DIV0) begin
                rdata_d = x_q[31:0];
            end else if (avs_address_i == OFS_DIV1) begin
                rdata_d = {28'h000_0000, x_q[35:32]};
            end else if (avs_address_i == OFS_QUO0) begin
                rdata_d = q_q[31:0];
            end else if (avs_address_i == OFS_QUO1) begin
                rdata_d = {28'h000_0000, q_q[35:32]};
            end else if (avs_address_i == OFS_IRQ_STAT) begin
                rdata_d = {30'h0000_0000, core.irq_stat};
            end else if (avs_address_i == OFS_IRQ_MASK) begin
                rdata_d = {30'h0000_0000, core.irq_mask};
            end else begin
                // Unmapped addresses read as zero
                rdata_d = RDATA_RST;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            acc_q <= ACC_RST;
            x_q <= WORD_RST;
            q_q <= WORD_RST;
            sk_q <= SK_ZERO;
            div_seq_q <= 1'b0;
            div_step_q <= 1'b0;
            restore_x_q <= 1'b0;
            delayed_add_q <= 1'b0;
            b_probe_q <= 1'b0;
            c_probe_q <= 1'b0;
            e_probe_q <= 1'b0;
            ext_seq_q <= 1'b0;
            div_case_q <= 1'b0;
            check_q <= 1'b0;
            done_q <= 1'b0;
            busy_q <= 1'b0;
            wait_q <= 1'b1;
            rdata_q <= RDATA_RST;
        end else begin
            state_q <= state_d;
            acc_q <= acc_d;
            x_q <= x_d;
            q_q <= q_d;
            sk_q <= sk_d;
            div_seq_q <= div_seq_d;
            div_step_q <= div_step_d;
            restore_x_q <= restore_x_d;
            delayed_add_q <= delayed_add_d;
            b_probe_q <= b_probe_d;
            c_probe_q <= c_probe_d;
            e_probe_q <= e_probe_d;
            ext_seq_q <= ext_seq_d;
            div_case_q <= div_case_d;
            check_q <= check_d;
            done_q <= done_d;
            busy_q <= busy_d;
            wait_q <= wait_d;
            rdata_q <= rdata_d;
        end
    end
    // Outputs straight from flops
    assign avs_readdata_o = rdata_q;
    assign avs_waitrequest_o = wait_q;
    assign irq_o = core.irq_out;
    assign busy_o = busy_q;
    assign div_check_stop_o = check_q;
    assign div_done_o = done_q;
    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);
    sequence seq_add_then_probe;
        delayed_add_q ##1 b_probe_q;
    endsequence
    AST_START_COUNT: assert property (
        $rose(div_seq_q) |-> sk_q == SK_FULL && div_step_q)
        else $error("divide phase did not start at full count");
    AST_STEP_ORDER: assert property (
        (state_q == ST_DIV && div_step_q) |=> seq_add_then_probe)
        else $error("division step order broken");
    AST_SAME_SIGN: assert property (
        (state_q == ST_DIV && div_step_q && same_sign) |=>
        q_q[0] && restore_x_q && x_q == ~$past(x_q) &&
        sk_q == $past(sk_q) - SK_ONE)
        else $error("subtracting step setup wrong");
    AST_DIFF_SIGN: assert property (
        (state_q == ST_DIV && div_step_q && !same_sign) |=>
        !restore_x_q && x_q == $past(x_q))
        else $error("adding step touched the divisor");
    AST_ZERO_NO_C: assert property (
        (state_q == ST_DIV && b_probe_q && sk_q == SK_ZERO) |=> !c_probe_q)
        else $error("final probe requested at zero count");
    AST_Q_ROTATE: assert property (
        finish |=> q_q == {$past(q_q[WORD_W-2:0]), $past(q_q[WORD_W-1])})
        else $error("quotient rotate wrong");
    AST_CHECK_ONE: assert property (
        (finish && sk_q == SK_AFTER_FIRST &&
         acc_q[SIGN_BIT] != acc_q[OVF_BIT]) |=> check_q && !busy_q)
        else $error("first divide check missed");
    AST_CHECK_TWO: assert property (
        (finish && sk_q == SK_AFTER_SECOND && q_q[0] == q_q[1]) |=>
        check_q && !busy_q)
        else $error("second divide check missed");
    AST_END_ENTRY: assert property (
        (finish && sk_q == SK_ZERO && !check_fail) |=>
        e_probe_q && !ext_seq_q ##1 done_q && !div_seq_q)
        else $error("end probe sequence wrong");
    AST_RESTORE: assert property (
        (finish && restore_x_q) |=> !restore_x_q &&
        x_q == ~$past(x_q))
        else $error("divisor not restored");
endmodule
`default_nettype wire

// *** dv/ndc_seq_model.sv ***
`default_nettype none
module ndc_seq_model (
    input wire logic clk_sys_i, // System clock
    input wire logic rst_i, // Async reset, high
    input wire logic stop_i, // Divide check stop pulse
    input wire logic done_i, // Completion pulse
    output logic [7:0] halt_count_o, // Fault halts taken
    output logic [7:0] resume_count_o // Normal resumes
);
    timeunit 1ns;
    timeprecision 1ps;
    // Halt with an arithmetic fault on a stop, resume on completion
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            halt_count_o <= 8'h00;
            resume_count_o <= 8'h00;
        end else begin
            if (stop_i) halt_count_o <= halt_count_o + 8'h01;
            if (done_i) resume_count_o <= resume_count_o + 8'h01;
        end
    end
endmodule
`default_nettype wire

// *** dv/nonrestoring_divide_core_tb.sv ***
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin \
    failures++; $display("BAD %s exp %h got %h", n, e, a); end end
module nonrestoring_divide_core_tb import ndc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0; // System clock
    logic rst_i = 1'b1; // Reset
    logic [7:0] avs_address_i = 8'h00; // Bus address
    logic avs_read_i = 1'b0; // Bus read
    logic avs_write_i = 1'b0; // Bus write
    logic [31:0] avs_writedata_i = 32'h0000_0000; // Bus write data
    logic [31:0] avs_readdata_o; // Bus read data
    logic avs_waitrequest_o, irq_o, busy_o, div_check_stop_o, div_done_o;
    logic [7:0] halts, resumes; // Sequencer model counts
    int failures = 0; // Mismatches
    int check_count = 0; // Comparisons
    always #2 clk_sys_i = ~clk_sys_i;
    ndc_divide_core dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o),
        .busy_o(busy_o), .div_check_stop_o(div_check_stop_o),
        .div_done_o(div_done_o));
    ndc_seq_model seq (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .stop_i(div_check_stop_o), .done_i(div_done_o),
        .halt_count_o(halts), .resume_count_o(resumes));
    ////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic stop_test();
        $display("failures %0d checks %0d", failures, check_count);
        if (failures == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // One bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys_i);
        avs_address_i <= a;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        avs_writedata_i <= d;
        // Only the watchdog ends a wait that never completes
        do begin
            @(posedge clk_sys_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0000_0000, q);
    endtask
    // Load operands, clear quotient, start, wait for stop or done
    task automatic run(input logic [71:0] a, input logic [35:0] x,
                       output logic st, output logic dn);
        int n;
        wr(OFS_ACC0, a[31:0]);
        wr(OFS_ACC1, a[63:32]);
        wr(OFS_ACC2, {24'h000000, a[71:64]});
        wr(OFS_DIV0, x[31:0]);
        wr(OFS_DIV1, {28'h0000000, x[35:32]});
        wr(OFS_QUO0, 32'h0000_0000);
        wr(OFS_QUO1, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0001);
        // Busy now: this write must be ignored
        wr(OFS_ACC0, 32'hFFFF_FFFF);
        st = 1'b0;
        dn = 1'b0;
        n = 0;
        while (!st && !dn && n < 2000) begin
            @(posedge clk_sys_i);
            st = (div_check_stop_o === 1'b1);
            dn = (div_done_o === 1'b1);
            n++;
        end
    endtask
    // Read accumulator and quotient back
    task automatic result(output logic [71:0] a, output logic [35:0] q);
        logic [31:0] r0, r1, r2;
        rd(OFS_ACC0, r0);
        rd(OFS_ACC1, r1);
        rd(OFS_ACC2, r2);
        a = {r2[7:0], r1, r0};
        rd(OFS_QUO0, r0);
        rd(OFS_QUO1, r1);
        q = {r1[3:0], r0};
    endtask
    ////////////////////////////////////////////////////////////////////
    // Idle state and unmapped read
    task automatic test_reset();
        logic [31:0] q;
        `CHK("wait0", 1'b1, avs_waitrequest_o)
        `CHK("irq0", 1'b0, irq_o)
        rd(OFS_STATUS, q);
        `CHK("status", 32'h0000_0000, q)
        rd(8'hFC, q);
        `CHK("unmapped", 32'h0000_0000, q)
    endtask
    // Positive over positive, unmasked done interrupt
    task automatic test_pos();
        logic st, dn;
        logic [71:0] a;
        logic [35:0] q;
        logic [31:0] r;
        wr(OFS_IRQ_MASK, 32'h0000_0001);
        run(72'hD, 36'h4, st, dn);
        `CHK("done", 2'b01, {st, dn})
        result(a, q);
        `CHK("quot", 36'h0_0000_0003, q)
        `CHK("rem", 72'h1, a)
        `CHK("irq", 1'b1, irq_o)
        rd(OFS_IRQ_STAT, r);
        `CHK("irqstat", 32'h0000_0001, r)
        wr(OFS_IRQ_STAT, 32'h0000_0001);
        repeat (2) @(posedge clk_sys_i);
        `CHK("irqclr", 1'b0, irq_o)
    endtask
    // Negative over negative with end correction, masked interrupt
    task automatic test_neg();
        logic st, dn;
        logic [71:0] a;
        logic [35:0] q;
        wr(OFS_IRQ_MASK, 32'h0000_0000);
        run(~72'h25, ~36'h7, st, dn);
        `CHK("done", 2'b01, {st, dn})
        result(a, q);
        `CHK("quot", 36'h0_0000_0005, q)
        `CHK("rem", 72'h5, a)
        `CHK("masked", 1'b0, irq_o)
        `CHK("resumes", 8'h02, resumes)
    endtask
    // Quotient too large: divide check stop
    task automatic test_ovf();
        logic st, dn;
        logic [31:0] r;
        wr(OFS_IRQ_STAT, 32'h0000_0003);
        wr(OFS_IRQ_MASK, 32'h0000_0002);
        run(72'h40_0000_0000_0000_0000, 36'h0_0000_0001, st, dn);
        `CHK("stop", 2'b10, {st, dn})
        @(posedge clk_sys_i);
        `CHK("busy", 1'b0, busy_o)
        `CHK("halts", 8'h01, halts)
        rd(OFS_IRQ_STAT, r);
        `CHK("irqstat", 32'h0000_0002, r)
        `CHK("irq", 1'b1, irq_o)
    endtask
    // Two subtractions in a row: only the second check can stop
    task automatic test_chk2();
        logic st, dn;
        logic [71:0] a;
        logic [35:0] q;
        run(72'h00_0000_0010_0000_0000, 36'h0_0000_0001, st, dn);
        `CHK("stop2", 2'b10, {st, dn})
        result(a, q);
        `CHK("q2", 36'h0_0000_0006, q)
        `CHK("a2", 72'h1, a)
        `CHK("halts2", 8'h02, halts)
    endtask
    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (6) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        test_reset();
        test_pos();
        test_neg();
        test_ovf();
        test_chk2();
        stop_test();
    end
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        failures++;
        stop_test();
    end
endmodule
`default_nettype wire
